//--- rtl/hcg_pkg.sv
`default_nettype none

package hcg_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS        = 4000;
    // main clock of the port is this block's own clock
    localparam int MAIN_CLOCK_PERIOD_PS = 4000;
    localparam int FLAG_CLEAR_CYC =
        (MAIN_CLOCK_PERIOD_PS / CLK_PERIOD_PS < 1) ? 1 :
        MAIN_CLOCK_PERIOD_PS / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          AXI_AW           = 6;
    localparam logic [5:0]  REG_CMD_LO       = 6'h00;
    localparam logic [5:0]  REG_CMD_HI       = 6'h04;
    localparam logic [5:0]  REG_RSP_LO       = 6'h08;
    localparam logic [5:0]  REG_RSP_HI       = 6'h0c;
    localparam logic [5:0]  REG_AUX_CMD_LO   = 6'h10;
    localparam logic [5:0]  REG_AUX_CMD_HI   = 6'h14;
    localparam logic [5:0]  REG_AUX_RSP_LO   = 6'h18;
    localparam logic [5:0]  REG_AUX_RSP_HI   = 6'h1c;
    localparam logic [5:0]  REG_HW_STATUS    = 6'h20;
    localparam logic [5:0]  REG_HW_ENABLE    = 6'h24;
    localparam logic [5:0]  REG_PIN_STATE    = 6'h28;

    // status and enable bit positions
    localparam int ST_CMD_ACCEPT = 0;
    localparam int ST_AUX_ACCEPT = 1;
    localparam int ST_RSP_PEND   = 2;
    localparam int ST_AUX_PEND   = 3;
    localparam int IE_RSP        = 0;
    localparam int IE_AUX        = 1;

    // ------------------------------------------------------------
    // commands and pins
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_DIR         = 8'h09;
    localparam logic [7:0]  OP_WRITE       = 8'h0b;
    localparam logic [15:0] CMD_PIN_READ   = 16'h5143;
    localparam logic [7:0]  HOST_PIN_MASK  = 8'hce;
    localparam logic [7:0]  RSV_PIN_MASK   = 8'h31;
    localparam logic [7:0]  DIR_RST        = 8'h31;
    localparam logic [7:0]  WR_VAL_RST     = 8'h00;
    localparam int          PIN_DATA_FLAG  = 0;
    localparam int          PIN_RSV        = 4;
    localparam int          PIN_FRAME_IRQ  = 5;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } hcg_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } hcg_axi_rsp_t;

    typedef struct packed {
        logic              aw_full;
        logic [AXI_AW-1:0] aw_addr;
        logic              w_full;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        cmd_lo;
        logic [15:0]       cmd_word;
        logic              cmd_busy;
        logic              cmd_accept;
        logic [15:0]       rsp;
        logic              rsp_pend;
        logic [7:0]        aux_lo;
        logic              aux_accept;
        logic              aux_cmd_valid;
        logic [15:0]       aux_cmd;
        logic [15:0]       aux_rsp;
        logic              aux_pend;
        logic [1:0]        irq_en;
        logic [7:0]        dir;
        logic [7:0]        wr_val;
        logic [7:0]        pad_meta;
        logic [7:0]        pad_sync;
        logic [7:0]        pin_out;
        logic              irq_n;
    } hcg_state_t;

    localparam hcg_state_t STATE_RST = '{
        dir:     DIR_RST,
        wr_val:  WR_VAL_RST,
        pin_out: 8'h00,
        irq_n:   1'b1,
        default: '0
    };

endpackage : hcg_pkg

`default_nettype wire

//--- rtl/hcg_gpio_port.sv
// How it works
// - eight pins, each input or output
// - pin 0 data flag, pin 5 frame interrupt
// - reset: reserved pins out, five host inputs
// - 09xx sets directions, reply forces 5,4,0
// - 0bxx latches values, inputs stay undriven
// - write reply echoes the written bits
// - write reply bits 0,4,5 show reserved outputs
// - pin 4 reserved, host cannot touch it
// - 5143 reads pins and frame interrupt
// - read reply upper byte: sensed pin levels
// - read reply lower byte: drive values, firmware on 0,4,5
// - latched value drives pin once made output
// - output pin reports pad, not written value
// - command upper byte write clears accept flag
// - aux command port clears its accept flag
// - flag clears before the next host access
// - posted reply sets response pending flag
// - host interrupt needs pending flag and enable
// - reading reply upper byte clears pending, irq
`timescale 1ns/10ps
`default_nettype none

module hcg_gpio_port (
    // clock, reset, enable
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    input  wire logic                  ce_in,
    // register bus
    input  wire hcg_pkg::hcg_axi_req_t axi_req_in,
    output var  hcg_pkg::hcg_axi_rsp_t axi_rsp_out,
    // firmware side
    input  wire logic                  fw_data_flag_out_n_in,
    input  wire logic                  fw_frame_irq_out_n_in,
    input  wire logic                  fw_rsv_out_in,
    input  wire logic                  aux_rsp_wr_in,
    input  wire logic [15:0]           aux_rsp_data_in,
    output logic                       aux_cmd_valid_out,
    output logic      [15:0]           aux_cmd_out,
    // pins
    input  wire logic [7:0]            gpio_pad_in,
    output logic      [7:0]            gpio_out_out,
    output logic      [7:0]            gpio_oe_out,
    output logic                       host_irq_n_out
);
    import hcg_pkg::*;

    localparam int CLR_BOUND = FLAG_CLEAR_CYC;

    hcg_state_t  s;
    hcg_state_t  nx;
    logic [7:0]  fw_vec;
    logic [7:0]  pin_src;
    logic        wr_go;
    logic        rd_go;
    logic        launch;
    logic [5:0]  wa;
    logic [5:0]  ra;

    // ------------------------------------------------------------
    // pin drive sources
    // ------------------------------------------------------------
    assign fw_vec = {2'b00, fw_frame_irq_out_n_in, fw_rsv_out_in,
                     3'b000, fw_data_flag_out_n_in};

    // reserved pins follow firmware, host pins their latch
    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign pin_src[i] = RSV_PIN_MASK[i] ? fw_vec[i]
                                            : s.wr_val[i];
    end

    // ------------------------------------------------------------
    // bus decode helpers
    // ------------------------------------------------------------
    assign wa     = {s.aw_addr[5:2], 2'b00};
    assign ra     = {axi_req_in.araddr[5:2], 2'b00};
    assign wr_go  = s.aw_full && s.w_full && !s.bvalid;
    assign rd_go  = axi_req_in.arvalid && !s.rvalid;
    assign launch = ce_in && wr_go && (wa == REG_CMD_HI) &&
                    s.w_strb[0] && s.cmd_accept;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nx               = s;
        nx.aux_cmd_valid = 1'b0;
        nx.cmd_busy      = 1'b0;
        nx.cmd_accept    = 1'b1;
        nx.aux_accept    = 1'b1;
        nx.pad_meta      = gpio_pad_in;
        nx.pad_sync      = s.pad_meta;
        nx.pin_out       = pin_src;

        // bus channel handshakes
        if (axi_req_in.awvalid && !s.aw_full) begin
            nx.aw_full = 1'b1;
            nx.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && !s.w_full) begin
            nx.w_full = 1'b1;
            nx.w_data = axi_req_in.wdata;
            nx.w_strb = axi_req_in.wstrb;
        end
        if (s.bvalid && axi_req_in.bready) begin
            nx.bvalid = 1'b0;
        end
        if (s.rvalid && axi_req_in.rready) begin
            nx.rvalid = 1'b0;
        end

        // register writes
        if (wr_go) begin
            nx.aw_full = 1'b0;
            nx.w_full  = 1'b0;
            nx.bvalid  = 1'b1;
            nx.bresp   = RESP_OKAY;
            if (wa == REG_CMD_LO) begin
                if (s.w_strb[0]) begin
                    nx.cmd_lo = s.w_data[7:0];
                end
            end else if (wa == REG_CMD_HI) begin
                // a word sent while busy is dropped; host must poll
                if (launch) begin
                    nx.cmd_word   = {s.w_data[7:0], s.cmd_lo};
                    nx.cmd_busy   = 1'b1;
                    nx.cmd_accept = 1'b0;
                end
            end else if (wa == REG_AUX_CMD_LO) begin
                if (s.w_strb[0]) begin
                    nx.aux_lo = s.w_data[7:0];
                end
            end else if (wa == REG_AUX_CMD_HI) begin
                if (s.w_strb[0] && s.aux_accept) begin
                    nx.aux_cmd       = {s.w_data[7:0], s.aux_lo};
                    nx.aux_cmd_valid = 1'b1;
                    nx.aux_accept    = 1'b0;
                end
            end else if (wa == REG_HW_ENABLE) begin
                if (s.w_strb[0]) begin
                    nx.irq_en = s.w_data[1:0];
                end
            end else if (wa == REG_RSP_LO || wa == REG_RSP_HI ||
                         wa == REG_AUX_RSP_LO ||
                         wa == REG_AUX_RSP_HI ||
                         wa == REG_HW_STATUS ||
                         wa == REG_PIN_STATE) begin
                nx.bresp = RESP_OKAY;
            end else begin
                nx.bresp = RESP_SLVERR;
            end
        end

        // register reads; clears come before sets so a set wins
        if (rd_go) begin
            nx.rvalid = 1'b1;
            nx.rresp  = RESP_OKAY;
            nx.rdata  = 32'h0000_0000;
            if (ra == REG_CMD_LO) begin
                nx.rdata[7:0] = s.cmd_lo;
            end else if (ra == REG_RSP_LO) begin
                nx.rdata[7:0] = s.rsp[7:0];
            end else if (ra == REG_RSP_HI) begin
                nx.rdata[7:0] = s.rsp[15:8];
                nx.rsp_pend   = 1'b0;
            end else if (ra == REG_AUX_CMD_LO) begin
                nx.rdata[7:0] = s.aux_lo;
            end else if (ra == REG_AUX_RSP_LO) begin
                nx.rdata[7:0] = s.aux_rsp[7:0];
            end else if (ra == REG_AUX_RSP_HI) begin
                nx.rdata[7:0] = s.aux_rsp[15:8];
                nx.aux_pend   = 1'b0;
            end else if (ra == REG_HW_STATUS) begin
                nx.rdata[ST_CMD_ACCEPT] = s.cmd_accept;
                nx.rdata[ST_AUX_ACCEPT] = s.aux_accept;
                nx.rdata[ST_RSP_PEND]   = s.rsp_pend;
                nx.rdata[ST_AUX_PEND]   = s.aux_pend;
            end else if (ra == REG_HW_ENABLE) begin
                nx.rdata[1:0] = s.irq_en;
            end else if (ra == REG_PIN_STATE) begin
                nx.rdata[23:0] = {s.dir, s.pad_sync, s.pin_out};
            end else if (ra == REG_CMD_HI ||
                         ra == REG_AUX_CMD_HI) begin
                nx.rresp = RESP_OKAY;
            end else begin
                nx.rresp = RESP_SLVERR;
            end
        end

        // command execution, one cycle after launch
        if (s.cmd_busy) begin
            case (s.cmd_word[15:8])
                OP_DIR: begin
                    nx.dir = (s.dir & ~HOST_PIN_MASK) |
                             (s.cmd_word[7:0] & HOST_PIN_MASK);
                    nx.rsp = {OP_DIR, s.cmd_word[7:6], 2'b11,
                              s.cmd_word[3:1], 1'b1};
                    nx.rsp_pend = 1'b1;
                end
                OP_WRITE: begin
                    // latch kept for inputs, pin only driven when out
                    nx.wr_val = (s.wr_val & ~HOST_PIN_MASK) |
                                (s.cmd_word[7:0] & HOST_PIN_MASK);
                    nx.rsp = {OP_WRITE, s.cmd_word[7:6],
                              s.pin_out[PIN_FRAME_IRQ],
                              s.pin_out[PIN_RSV],
                              s.cmd_word[3:1],
                              s.pin_out[PIN_DATA_FLAG]};
                    nx.rsp_pend = 1'b1;
                end
                default: begin
                    if (s.cmd_word == CMD_PIN_READ) begin
                        // pad level, even if an output is forced
                        nx.rsp = {s.pad_sync,
                                  s.pin_out};
                        nx.rsp_pend = 1'b1;
                    end
                end
            endcase
        end

        if (aux_rsp_wr_in) begin
            nx.aux_rsp  = aux_rsp_data_in;
            nx.aux_pend = 1'b1;
        end

        nx.irq_n = !((nx.rsp_pend && nx.irq_en[IE_RSP]) ||
                     (nx.aux_pend && nx.irq_en[IE_AUX]));
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s <= STATE_RST;
        end else if (ce_in) begin
            s <= nx;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // readies drop with ce_in so no beat is taken while frozen
    always_comb begin
        axi_rsp_out.awready = ce_in && !s.aw_full;
        axi_rsp_out.wready  = ce_in && !s.w_full;
        axi_rsp_out.bvalid  = s.bvalid;
        axi_rsp_out.bresp   = s.bresp;
        axi_rsp_out.arready = ce_in && !s.rvalid;
        axi_rsp_out.rvalid  = s.rvalid;
        axi_rsp_out.rdata   = s.rdata;
        axi_rsp_out.rresp   = s.rresp;
    end

    assign gpio_out_out      = s.pin_out;
    assign gpio_oe_out       = s.dir;
    assign host_irq_n_out    = s.irq_n;
    assign aux_cmd_valid_out = s.aux_cmd_valid;
    assign aux_cmd_out       = s.aux_cmd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_dir;
        @(posedge clk_in)
        $rose(nrst_in) |-> (gpio_oe_out == DIR_RST);
    endproperty
    a_reset_dir: assert property (p_reset_dir)
        else $error("pin directions wrong after reset");

    property p_rsv_out;
        @(posedge clk_in) disable iff (!nrst_in)
        (gpio_oe_out & RSV_PIN_MASK) == RSV_PIN_MASK;
    endproperty
    a_rsv_out: assert property (p_rsv_out)
        else $error("reserved pin not an output");

    property p_flag_pin;
        @(posedge clk_in) disable iff (!nrst_in)
        ce_in |=> (gpio_out_out[PIN_DATA_FLAG] ==
                   $past(fw_data_flag_out_n_in)) &&
                  (gpio_out_out[PIN_FRAME_IRQ] ==
                   $past(fw_frame_irq_out_n_in));
    endproperty
    a_flag_pin: assert property (p_flag_pin)
        else $error("reserved pin not following firmware");

    property p_cmd_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        launch |-> ##[1:CLR_BOUND] !s.cmd_accept;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear)
        else $error("accept flag not cleared after command");

    property p_reply;
        @(posedge clk_in) disable iff (!nrst_in)
        launch ##1 ce_in |=> s.cmd_accept &&
            (s.rsp_pend == ($past(s.cmd_word[15:8]) == OP_DIR ||
                            $past(s.cmd_word[15:8]) == OP_WRITE ||
                            $past(s.cmd_word) == CMD_PIN_READ ||
                            ($past(s.rsp_pend) && !($past(rd_go) &&
                             $past(ra) == REG_RSP_HI))));
    endproperty
    a_reply: assert property (p_reply)
        else $error("accept or reply wrong after command");

    property p_dir_cmd;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && s.cmd_busy && s.cmd_word[15:8] == OP_DIR) |=>
            gpio_oe_out == (($past(gpio_oe_out) & ~HOST_PIN_MASK) |
                            ($past(s.cmd_word[7:0]) & HOST_PIN_MASK));
    endproperty
    a_dir_cmd: assert property (p_dir_cmd)
        else $error("direction command not applied");

    property p_read_reply;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && s.cmd_busy && s.cmd_word == CMD_PIN_READ) |=>
            s.rsp == {$past(s.pad_sync), $past(gpio_out_out)};
    endproperty
    a_read_reply: assert property (p_read_reply)
        else $error("pin read reply wrong");

    property p_irq_cause;
        @(posedge clk_in) disable iff (!nrst_in)
        !host_irq_n_out |-> (s.rsp_pend && s.irq_en[IE_RSP]) ||
                            (s.aux_pend && s.irq_en[IE_AUX]);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled pending flag");

    property p_rsp_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && rd_go && ra == REG_RSP_HI && !s.cmd_busy && !wr_go &&
         !(s.aux_pend && s.irq_en[IE_AUX]) && !aux_rsp_wr_in)
            |=> !s.rsp_pend && host_irq_n_out;
    endproperty
    a_rsp_clear: assert property (p_rsp_clear)
        else $error("reply read did not clear pending");

    property p_aux_set;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && aux_rsp_wr_in) |=> s.aux_pend;
    endproperty
    a_aux_set: assert property (p_aux_set)
        else $error("aux reply did not set pending");

    property p_aux_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && wr_go && wa == REG_AUX_CMD_HI && s.w_strb[0] &&
         s.aux_accept) |=> !s.aux_accept && aux_cmd_valid_out;
    endproperty
    a_aux_clear: assert property (p_aux_clear)
        else $error("aux command did not clear its accept flag");

    property p_write_reply;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && s.cmd_busy && s.cmd_word[15:8] == OP_WRITE) |=>
            (s.rsp[15:8] == OP_WRITE) &&
            ((s.rsp[7:0] & HOST_PIN_MASK) ==
             ($past(s.cmd_word[7:0]) & HOST_PIN_MASK)) &&
            ((s.rsp[7:0] & RSV_PIN_MASK) ==
             ($past(gpio_out_out) & RSV_PIN_MASK));
    endproperty
    a_write_reply: assert property (p_write_reply)
        else $error("pin write reply wrong");

    // a write only moves the latch, never a direction
    property p_write_dir;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && s.cmd_busy && s.cmd_word[15:8] == OP_WRITE) |=>
            $stable(gpio_oe_out);
    endproperty
    a_write_dir: assert property (p_write_dir)
        else $error("pin write changed a direction");

endmodule : hcg_gpio_port

`default_nettype wire

//--- verification/hcg_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module hcg_pad_model (
    // drive from the block
    input  wire logic [7:0] out_in,
    input  wire logic [7:0] oe_in,
    // outside driver and shorts to ground
    input  wire logic [7:0] ext_in,
    input  wire logic [7:0] short_in,
    // sensed levels
    output logic      [7:0] pad_out
);
    // ------------
    // a short beats the drive, so readback and pad can differ
    // ------------
    assign pad_out = (oe_in & out_in & ~short_in)
                   | (~oe_in & ext_in);
endmodule : hcg_pad_model
`default_nettype wire

//--- verification/test_host_commanded_gpio_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_host_commanded_gpio_port;
    import hcg_pkg::*;
    logic         clk_in;
    logic         nrst_in;
    hcg_axi_req_t req;
    hcg_axi_rsp_t rsp;
    logic [7:0]   fw, ext, sh, gout, goe, pad, dir, lat, b;
    logic         aux_wr, aux_vld, irq_n, ce;
    logic [15:0]  aux_d, aux_cmd;
    logic [1:0]   en;
    logic [31:0]  k, j;
    logic [65:0]  e;
    integer       seed, fail_count, compares;
    logic [65:0]  rq[$];
    logic [1:0]   bq[$];
    logic [15:0]  aq[$];
    hcg_gpio_port hcg_gpio_port_inst (
        .clk_in               (clk_in),
        .nrst_in              (nrst_in),
        .ce_in                (ce),
        .axi_req_in           (req),
        .axi_rsp_out          (rsp),
        .fw_data_flag_out_n_in(fw[0]),
        .fw_frame_irq_out_n_in(fw[5]),
        .fw_rsv_out_in        (fw[4]),
        .aux_rsp_wr_in        (aux_wr),
        .aux_rsp_data_in      (aux_d),
        .aux_cmd_valid_out    (aux_vld),
        .aux_cmd_out          (aux_cmd),
        .gpio_pad_in          (pad),
        .gpio_out_out         (gout),
        .gpio_oe_out          (goe),
        .host_irq_n_out       (irq_n)
    );
    hcg_pad_model hcg_pad_model_inst (
        .out_in  (gout),
        .oe_in   (goe),
        .ext_in  (ext),
        .short_in(sh),
        .pad_out (pad)
    );
    // ------------
    // bus tasks and checks
    // ------------
    function automatic logic [7:0] drv();
        drv = (lat & HOST_PIN_MASK) | (fw & RSV_PIN_MASK);
    endfunction : drv
    function automatic logic [7:0] pads();
        pads = (dir & drv() & ~sh) | (~dir & ext);
    endfunction : pads
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] m);
        compares++;
        if ((got & m) !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // ready is looked at on the falling edge, where it is settled
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk_in);
        bq.push_back(r);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.bready  <= 1'b1;
        while (!tb) begin
            @(negedge clk_in);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tb = rsp.bvalid;
            @(posedge clk_in);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk_in);
        rq.push_back({m, r, d});
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        while (!tr) begin
            @(negedge clk_in);
            ta = req.arvalid & rsp.arready;
            tr = rsp.rvalid;
            @(posedge clk_in);
            if (ta) req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
    endtask : rd
    task automatic cmd(input logic [15:0] c, input logic [15:0] rp,
                       input logic ok);
        wr(REG_CMD_LO, {24'h0, c[7:0]}, RESP_OKAY);
        wr(REG_CMD_HI, {24'h0, c[15:8]}, RESP_OKAY);
        rd(REG_HW_STATUS, {29'h0, ok, 2'b01}, 32'h5, RESP_OKAY);
        if (ok) begin
            @(negedge clk_in);
            chk({31'h0, irq_n}, {31'h0, ~en[0]}, '1);
            rd(REG_RSP_LO, {24'h0, rp[7:0]}, '1, RESP_OKAY);
            rd(REG_RSP_HI, {24'h0, rp[15:8]}, '1, RESP_OKAY);
            @(negedge clk_in);
            chk({31'h0, irq_n}, 32'h1, '1);
            rd(REG_HW_STATUS, 32'h1, 32'h5, RESP_OKAY);
        end
    endtask : cmd
    task automatic complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    always @(negedge clk_in) begin
        if (nrst_in && rsp.rvalid && req.rready) begin
            e = rq.pop_front();
            chk(rsp.rdata, e[31:0], e[65:34]);
            chk({30'h0, rsp.rresp}, {30'h0, e[33:32]}, '1);
        end
        if (nrst_in && rsp.bvalid && req.bready)
            chk({30'h0, rsp.bresp}, {30'h0, bq.pop_front()}, '1);
        if (nrst_in && aux_vld)
            chk({16'h0, aux_cmd}, {16'h0, aq.pop_front()}, '1);
    end
    // ------------
    // scenarios
    // ------------
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        repeat (8000) @(posedge clk_in);
        fail_count++;
        complete_run();
    end
    initial begin
        seed = 64;
        fail_count = 0;
        compares = 0;
        req = '0;
        req.wstrb = 4'hf;
        nrst_in = 1'b0;
        ce = 1'b1;
        fw = 8'h00;
        ext = 8'h5a;
        sh = 8'h00;
        aux_wr = 1'b0;
        aux_d = 16'h0;
        dir = DIR_RST;
        lat = WR_VAL_RST;
        en = 2'b00;
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(REG_HW_STATUS, 32'h3, 32'hf, RESP_OKAY);
        rd(REG_HW_ENABLE, 32'h0, '1, RESP_OKAY);
        rd(REG_PIN_STATE, {8'h0, DIR_RST, pads(), drv()},
           '1, RESP_OKAY);
        wr(REG_CMD_LO, 32'h5a, RESP_OKAY);
        rd(REG_CMD_LO, 32'h5a, '1, RESP_OKAY);
        rd(REG_CMD_HI, 32'h0, '1, RESP_OKAY);
        wr(6'h3c, 32'h1, RESP_SLVERR);
        rd(6'h3c, 32'h0, '1, RESP_SLVERR);
        // opcode, pin byte, shorts and firmware levels all random
        for (int i = 0; i < 28; i++) begin
            k = $random(seed);
            j = $random(seed);
            b = j[7:0];
            en = k[1:0];
            fw <= k[15:8];
            ext <= k[23:16];
            sh <= k[31:24] & k[30:23];
            wr(REG_HW_ENABLE, {30'h0, k[1:0]}, RESP_OKAY);
            case (k[3:2])
                2'd0: begin
                    cmd({OP_DIR, b}, {OP_DIR, (b & HOST_PIN_MASK)
                        | RSV_PIN_MASK}, 1'b1);
                    dir = (b & HOST_PIN_MASK) | RSV_PIN_MASK;
                end
                2'd1: begin
                    cmd({OP_WRITE, b}, {OP_WRITE, (b & HOST_PIN_MASK)
                        | (drv() & RSV_PIN_MASK)}, 1'b1);
                    lat = (lat & ~HOST_PIN_MASK) | (b & HOST_PIN_MASK);
                end
                2'd2: cmd(CMD_PIN_READ, {pads(), drv()}, 1'b1);
                default: cmd({8'h1f, b}, 16'h0, 1'b0);
            endcase
            rd(REG_PIN_STATE, {8'h0, dir, pads(), drv()},
               '1, RESP_OKAY);
        end
        en = 2'b10;
        wr(REG_HW_ENABLE, 32'h2, RESP_OKAY);
        wr(REG_AUX_CMD_LO, 32'ha5, RESP_OKAY);
        aq.push_back(16'h3ca5);
        wr(REG_AUX_CMD_HI, 32'h3c, RESP_OKAY);
        @(posedge clk_in);
        aux_d <= 16'hc3e1;
        aux_wr <= 1'b1;
        @(posedge clk_in);
        aux_wr <= 1'b0;
        rd(REG_HW_STATUS, 32'h8, 32'hc, RESP_OKAY);
        @(negedge clk_in);
        chk({31'h0, irq_n}, 32'h0, '1);
        rd(REG_AUX_RSP_LO, 32'he1, '1, RESP_OKAY);
        rd(REG_AUX_RSP_HI, 32'hc3, '1, RESP_OKAY);
        @(negedge clk_in);
        chk({31'h0, irq_n}, 32'h1, '1);
        rd(REG_HW_STATUS, 32'h0, 32'hc, RESP_OKAY);
        // a reply pulse while frozen is lost, readies low meanwhile
        ce <= 1'b0;
        aux_wr <= 1'b1;
        @(posedge clk_in);
        aux_wr <= 1'b0;
        @(posedge clk_in);
        ce <= 1'b1;
        rd(REG_HW_STATUS, 32'h3, 32'hf, RESP_OKAY);
        // second reset in mid-run, directions back to defaults
        nrst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        dir = DIR_RST;
        lat = WR_VAL_RST;
        rd(REG_HW_STATUS, 32'h3, 32'hf, RESP_OKAY);
        rd(REG_PIN_STATE, {8'h0, DIR_RST, pads(), drv()},
           '1, RESP_OKAY);
        complete_run();
    end
endmodule : test_host_commanded_gpio_port
`default_nettype wire
